// >>> src/rx_fifo_mem.v
module rx_fifo_mem (
   // clock
   input  wire       clk,
   // write side
   input  wire       we,
   input  wire [3:0] waddr,
   input  wire [7:0] wdata,
   // read side
   input  wire [3:0] raddr,
   output reg  [7:0] rdata
);

   reg [7:0] mem [0:15];

   // write-first so a push into an empty fifo shows at once
   always @(posedge clk)
   begin
      if (we)
         mem[waddr] <= wdata;
      if (we && waddr == raddr)
         rdata <= wdata;
      else
         rdata <= mem[raddr];
   end

endmodule

// >>> src/sync_two_ff.v
module sync_two_ff #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // asynchronous in, synchronous out
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   // idle level of every line is high, so reset to ones
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1   <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// >>> src/uart_afc_regs.vh
`ifndef UART_AFC_REGS_VH
`define UART_AFC_REGS_VH
// register byte offsets
`define ADDR_DATA      8'h00
`define ADDR_IER       8'h04
`define ADDR_FCR       8'h08
`define ADDR_MCR       8'h10
`define ADDR_MSR       8'h18
`define ADDR_MER       8'h1C
`define ADDR_DIV       8'h20
`define ADDR_ISR       8'h24
`define ADDR_IMR       8'h28
`define ADDR_STAT      8'h2C
// modem control fields
`define MCR_RTS        1
`define MCR_RSVD       5
`define MCR_AUTO_RTS   6
`define MCR_AUTO_CTS   7
// enables and fifo control fields
`define IER_CTS_IRQ    7
`define MER_MODEM_IRQ  3
`define FCR_TRIG_HI    7
`define FCR_TRIG_LO    6
// receive trigger levels, lowest first
`define TRIG_LVL0      5'h01
`define TRIG_LVL1      5'h04
`define TRIG_LVL2      5'h08
`define TRIG_LVL3      5'h0E
`define TRIG_NONE      5'h00
`define FIFO_FULL      5'h10
// interrupt status fields
`define IRQ_MODEM      0
`define IRQ_RX         1
`define IRQ_TX         2
// reset values
`define DIV_RESET      16'h0010
`define ZERO32         32'h0000_0000
`endif

// >>> src/uart_auto_flow_control.v
// Summary of operation
// - control bit 6 enables automatic rts
// - control bit 7 enables automatic cts
// - rts goes high at receive trigger level
// - rts low again at next lower level
// - auto rts: bit reads pin, writes ignored
// - manual rts follows software control bit
// - one more character still stored after rts
// - auto cts: start character only if cts low
// - cts high: finish character, hold line high
// - cts low again: start bit, next character
// - any cts change sets delta cts flag
// - modem interrupt enable zero blocks interrupt
// - delta cts counts unless auto cts masked
`include "uart_afc_regs.vh"
module uart_auto_flow_control (
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // serial and modem pins
   input  wire        rxd,
   input  wire        cts_n,
   input  wire        dsr_n,
   input  wire        ri_n,
   input  wire        dcd_n,
   output reg         txd,
   output reg         rts_n,
   // interrupt
   output reg         irq
);

   localparam TX_IDLE  = 2'b00;
   localparam TX_START = 2'b01;
   localparam TX_DATA  = 2'b10;
   localparam TX_STOP  = 2'b11;
   localparam RX_IDLE  = 2'b00;
   localparam RX_START = 2'b01;
   localparam RX_DATA  = 2'b10;
   localparam RX_STOP  = 2'b11;

   reg        auto_request_flow_enable;
   reg        auto_clear_flow_enable;
   reg        rts_sw;
   reg        cts_irq_en;
   reg        modem_irq_en;
   reg [1:0]  trig_sel;
   reg [15:0] divisor;
   reg [2:0]  int_status;
   reg [2:0]  int_mask;
   reg [3:0]  msr_delta;
   reg [3:0]  modem_prev;
   reg [7:0]  thr;
   reg        thr_full;
   reg [1:0]  tx_state;
   reg [7:0]  tx_shift;
   reg [2:0]  tx_bit;
   reg [15:0] tx_cnt;
   reg [1:0]  rx_state;
   reg [7:0]  rx_shift;
   reg [2:0]  rx_bit;
   reg [15:0] rx_cnt;
   reg        rx_done;
   reg [4:0]  count;
   reg [3:0]  wr_ptr;
   reg [3:0]  rd_ptr;
   reg [4:0]  trig_level;
   reg [4:0]  lower_level;
   reg        hit;
   reg [31:0] rd_mux;

   wire [4:0] sync_out;
   wire [7:0] fifo_head;

   // synchronised pins: {rxd, dcd, ri, dsr, cts}
   sync_two_ff #(
      .WIDTH    (5)
   ) u_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in ({rxd, dcd_n, ri_n, dsr_n, cts_n}),
      .sync_out (sync_out)
   );

   wire rx_line    = sync_out[4];
   wire cts_active = ~sync_out[0];

   // apb phases
   wire setup  = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr     = access & pwrite;
   wire rd     = access & ~pwrite;

   // shared bit-rate tick for the transmitter
   wire tx_tick = ({1'b0, tx_cnt} + 17'h0_0001) >= {1'b0, divisor};
   wire rx_full_bit = ({1'b0, rx_cnt} + 17'h0_0001) >= {1'b0, divisor};

   // fifo control
   wire fifo_full = (count == `FIFO_FULL);
   wire push      = rx_done & ~fifo_full;
   wire pop       = rd & (paddr == `ADDR_DATA) & (count != `TRIG_NONE);
   wire [3:0] next_rd_ptr = rd_ptr + {3'b000, pop};

   rx_fifo_mem u_mem (
      .clk   (pclk),
      .we    (push),
      .waddr (wr_ptr),
      .wdata (rx_shift),
      .raddr (next_rd_ptr),
      .rdata (fifo_head)
   );

   // transmitter may begin a character
   wire can_start = thr_full &
                    (~auto_clear_flow_enable | cts_active);
   wire tx_load = tx_tick & can_start &
                  (tx_state == TX_IDLE || tx_state == TX_STOP);

   // modem status events
   wire [3:0] modem_chg = sync_out[3:0] ^ modem_prev;
   wire [3:0] modem_ev  = {modem_chg[3],
                           ~modem_prev[2] & sync_out[2],
                           modem_chg[1],
                           modem_chg[0]};
   wire msr_rd = rd & (paddr == `ADDR_MSR);

   // cts deltas are quiet in auto mode unless explicitly enabled
   wire modem_cond = modem_irq_en & (|msr_delta[3:1] |
                     (msr_delta[0] & (~auto_clear_flow_enable |
                      cts_irq_en)));

   wire [2:0] irq_ev = {tx_load, push, modem_cond};

   always @*
   begin
      case (trig_sel)
         2'b00:
         begin
            trig_level  = `TRIG_LVL0;
            lower_level = `TRIG_NONE;
         end
         2'b01:
         begin
            trig_level  = `TRIG_LVL1;
            lower_level = `TRIG_LVL0;
         end
         2'b10:
         begin
            trig_level  = `TRIG_LVL2;
            lower_level = `TRIG_LVL1;
         end
         default:
         begin
            trig_level  = `TRIG_LVL3;
            lower_level = `TRIG_LVL2;
         end
      endcase
   end

   // read mux and decode
   always @*
   begin
      hit    = 1'b1;
      rd_mux = `ZERO32;
      case (paddr)
         `ADDR_DATA:
            rd_mux[7:0] = fifo_head;
         `ADDR_IER:
            rd_mux[`IER_CTS_IRQ] = cts_irq_en;
         `ADDR_FCR:
            rd_mux[`FCR_TRIG_HI:`FCR_TRIG_LO] = trig_sel;
         `ADDR_MCR:
         begin
            rd_mux[`MCR_RTS] = auto_request_flow_enable ?
                               ~rts_n : rts_sw;
            rd_mux[`MCR_RSVD]     = 1'b0;
            rd_mux[`MCR_AUTO_RTS] = auto_request_flow_enable;
            rd_mux[`MCR_AUTO_CTS] = auto_clear_flow_enable;
         end
         `ADDR_MSR:
            rd_mux[7:0] = {~sync_out[3:0], msr_delta};
         `ADDR_MER:
            rd_mux[`MER_MODEM_IRQ] = modem_irq_en;
         `ADDR_DIV:
            rd_mux[15:0] = divisor;
         `ADDR_ISR:
            rd_mux[2:0] = int_status;
         `ADDR_IMR:
            rd_mux[2:0] = int_mask;
         `ADDR_STAT:
            rd_mux[6:0] = {thr_full, tx_state != TX_IDLE, count};
         default:
            hit = 1'b0;
      endcase
   end

   // apb answer, no wait states
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `ZERO32;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= (setup & ~pwrite) ? rd_mux : `ZERO32;
      end
   end

   // software registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         auto_request_flow_enable <= 1'b0;
         auto_clear_flow_enable   <= 1'b0;
         rts_sw       <= 1'b0;
         cts_irq_en   <= 1'b0;
         modem_irq_en <= 1'b0;
         trig_sel     <= 2'b00;
         divisor      <= `DIV_RESET;
         int_mask     <= 3'b000;
      end
      else if (wr)
      begin
         case (paddr)
            `ADDR_MCR:
            begin
               auto_request_flow_enable <= pwdata[`MCR_AUTO_RTS];
               auto_clear_flow_enable   <= pwdata[`MCR_AUTO_CTS];
               if (!auto_request_flow_enable)
                  rts_sw <= pwdata[`MCR_RTS];
            end
            `ADDR_IER:
               cts_irq_en <= pwdata[`IER_CTS_IRQ];
            `ADDR_MER:
               modem_irq_en <= pwdata[`MER_MODEM_IRQ];
            `ADDR_FCR:
               trig_sel <= pwdata[`FCR_TRIG_HI:`FCR_TRIG_LO];
            `ADDR_DIV:
               divisor <= pwdata[15:0];
            `ADDR_IMR:
               int_mask <= pwdata[2:0];
            default:
               trig_sel <= trig_sel;
         endcase
      end
   end

   // sticky status: events win over clears
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_status <= 3'b000;
         msr_delta  <= 4'h0;
         modem_prev <= 4'hF;
         irq        <= 1'b0;
      end
      else
      begin
         modem_prev <= sync_out[3:0];
         msr_delta  <= (msr_delta & {4{~msr_rd}}) | modem_ev;
         int_status <= (int_status &
                        ~({3{wr & (paddr == `ADDR_ISR)}} & pwdata[2:0]))
                       | irq_ev;
         irq        <= |(int_status & int_mask);
      end
   end

   // rts drive with hysteresis between trigger levels
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rts_n <= 1'b1;
      else if (!auto_request_flow_enable)
         rts_n <= ~rts_sw;
      else if (count >= trig_level)
         rts_n <= 1'b1;
      else if (count <= lower_level)
         rts_n <= 1'b0;
   end

   // receive fifo pointers; room above any trigger keeps late bytes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count  <= 5'h00;
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 4'h1;
         rd_ptr <= next_rd_ptr;
         if (push && !pop)
            count <= count + 5'h01;
         else if (pop && !push)
            count <= count - 5'h01;
      end
   end

   // transmitter
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         thr      <= 8'h00;
         thr_full <= 1'b0;
         tx_state <= TX_IDLE;
         tx_shift <= 8'h00;
         tx_bit   <= 3'b000;
         tx_cnt   <= 16'h0000;
         txd      <= 1'b1;
      end
      else
      begin
         if (wr && paddr == `ADDR_DATA && !thr_full)
         begin
            thr      <= pwdata[7:0];
            thr_full <= 1'b1;
         end
         tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
         if (tx_load)
         begin
            thr_full <= 1'b0;
            tx_shift <= thr;
            tx_state <= TX_START;
            txd      <= 1'b0;
         end
         else if (tx_tick)
         begin
            case (tx_state)
               TX_START:
               begin
                  txd      <= tx_shift[0];
                  tx_shift <= {1'b1, tx_shift[7:1]};
                  tx_bit   <= 3'b000;
                  tx_state <= TX_DATA;
               end
               TX_DATA:
               begin
                  tx_bit <= tx_bit + 3'b001;
                  if (tx_bit == 3'b111)
                  begin
                     txd      <= 1'b1;
                     tx_state <= TX_STOP;
                  end
                  else
                  begin
                     txd      <= tx_shift[0];
                     tx_shift <= {1'b1, tx_shift[7:1]};
                  end
               end
               default:
               begin
                  // stalled or empty: line stays marking
                  txd      <= 1'b1;
                  tx_state <= TX_IDLE;
               end
            endcase
         end
      end
   end

   // receiver, mid-bit sampling
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_state <= RX_IDLE;
         rx_shift <= 8'h00;
         rx_bit   <= 3'b000;
         rx_cnt   <= 16'h0000;
         rx_done  <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         case (rx_state)
            RX_IDLE:
            begin
               rx_cnt <= 16'h0000;
               if (!rx_line)
                  rx_state <= RX_START;
            end
            RX_START:
            begin
               rx_cnt <= rx_cnt + 16'h0001;
               if (rx_cnt >= {1'b0, divisor[15:1]})
               begin
                  rx_cnt   <= 16'h0000;
                  rx_bit   <= 3'b000;
                  rx_state <= rx_line ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA:
            begin
               rx_cnt <= rx_cnt + 16'h0001;
               if (rx_full_bit)
               begin
                  rx_cnt   <= 16'h0000;
                  rx_shift <= {rx_line, rx_shift[7:1]};
                  rx_bit   <= rx_bit + 3'b001;
                  if (rx_bit == 3'b111)
                     rx_state <= RX_STOP;
               end
            end
            default:
            begin
               rx_cnt <= rx_cnt + 16'h0001;
               if (rx_full_bit)
               begin
                  rx_cnt   <= 16'h0000;
                  rx_done  <= rx_line;
                  rx_state <= RX_IDLE;
               end
            end
         endcase
      end
   end

endmodule

// >>> test/uart_afc_sva.sv
`include "uart_afc_regs.vh"
module uart_afc_sva (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins
   input wire logic        txd,
   input wire logic        rts_n,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire hit = paddr inside {`ADDR_DATA, `ADDR_IER, `ADDR_FCR, `ADDR_MCR,
      `ADDR_MSR, `ADDR_MER, `ADDR_DIV, `ADDR_ISR, `ADDR_IMR, `ADDR_STAT};
   wire rd_mcr = pready && !pwrite && paddr == `ADDR_MCR;
   property p_answer;
      psel && !penable |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("ready missing");
   property p_single;
      pready |=> !pready;
   endproperty
   a_single: assert property (p_single) else $error("ready too long");
   property p_unmapped;
      pready && !hit |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no slave error");
   property p_mapped;
      pready && hit |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("false slave error");
   property p_idle;
      !pready |-> prdata == 32'h0 && !pslverr;
   endproperty
   a_idle: assert property (p_idle) else $error("bus not quiet");
   property p_rsvd;
      rd_mcr |-> prdata[5] == 1'b0 && prdata[31:8] == 24'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved set");
   property p_reflect;
      rd_mcr && prdata[6] |-> prdata[1] == !$past(rts_n);
   endproperty
   a_reflect: assert property (p_reflect) else $error("rts bit");
   // rts_n is registered behind the control bit, hence the extra cycle
   property p_manual;
      pready && pwrite && paddr == `ADDR_MCR && !pwdata[6]
         |=> ##1 rts_n == !$past(pwdata[1], 2);
   endproperty
   a_manual: assert property (p_manual) else $error("rts pin");
   property p_start;
      $fell(txd) |-> (!txd) [*8];
   endproperty
   a_start: assert property (p_start) else $error("short start");
   c_err: cover property (pready && pslverr);
   c_auto: cover property (rd_mcr && prdata[7]);
   c_start: cover property ($fell(txd));
   c_irq: cover property ($rose(irq));
endmodule
bind uart_auto_flow_control uart_afc_sva chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .txd(txd), .rts_n(rts_n), .irq(irq)
);

// >>> test/uart_auto_flow_control_tb.sv
`include "uart_afc_regs.vh"
module uart_auto_flow_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, b;
   logic [31:0] pwdata, prdata, rd, lfsr;
   logic        rxd, cts_n, dsr_n, ri_n, dcd_n, txd, rts_n, irq;
   logic        go, cts_req, er, rts_m, hi;
   logic [7:0]  rx_q[$], tx_q[$];
   int          mismatches, n_tests, cnt, i;
   uart_auto_flow_control dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n),
      .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .txd(txd),
      .rts_n(rts_n), .irq(irq)
   );
   uart_partner #(.BIT(`DIV_RESET)) far_u (
      .pclk(pclk), .rts_n(rts_n), .go(go), .cts_req(cts_req),
      .rxd(rxd), .cts_n(cts_n)
   );
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic give_verdict;
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic hang;
      mismatches++;
      $display("ERROR wait exp done got timeout");
      give_verdict;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_pin(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         hang;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // samples each bit at its middle, one bit is sixteen cycles
   task automatic get_tx(output logic [7:0] v);
      int n;
      n = 0;
      while (txd !== 1'b0 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 2000)
         hang;
      repeat (8) @(posedge pclk);
      for (int j = 0; j < 8; j++)
      begin
         repeat (16) @(posedge pclk);
         v[j] = txd;
      end
      repeat (16) @(posedge pclk);
      chk_pin("stop bit", 1'b1, txd);
   endtask
   task automatic hold_high(input int n);
      hi = 1'b1;
      repeat (n)
      begin
         @(posedge pclk);
         hi = hi & txd;
      end
   endtask
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {presetn, go, mismatches, n_tests} = '0;
      {cts_req, dsr_n, ri_n, dcd_n} = 4'hF;
      lfsr = 32'h0000_70c6;
      for (i = 0; i < 2; i++)
      begin
         lfsr = nxt(lfsr);
         tx_q.push_back(lfsr[7:0]);
      end
      for (i = 0; i < 5; i++)
         rx_q.push_back(8'(8'h30 + i));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADDR_MCR, 32'h0);
      chk("mcr reset", 32'h0, rd);
      chk_pin("rts reset", 1'b1, rts_n);
      apb(1'b1, `ADDR_MCR, 32'h0000_0022);
      apb(1'b0, `ADDR_MCR, 32'h0);
      chk("mcr read", 32'h0000_0002, rd);
      chk_pin("rts manual", 1'b0, rts_n);
      apb(1'b0, 8'h3C, 32'h0);
      chk_pin("slave error", 1'b1, er);
      apb(1'b1, `ADDR_MCR, 32'h0000_0080);
      cts_req <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, `ADDR_DATA, {24'h0, tx_q[0]});
      hold_high(300);
      chk_pin("txd held", 1'b1, hi);
      cts_req <= 1'b1;
      fork
         get_tx(b);
         begin
            repeat (60) @(posedge pclk);
            apb(1'b1, `ADDR_DATA, {24'h0, tx_q[1]});
            cts_req <= 1'b0;
         end
      join
      chk("tx byte", {24'h0, tx_q.pop_front()}, {24'h0, b});
      hold_high(300);
      chk_pin("txd stall", 1'b1, hi);
      cts_req <= 1'b1;
      get_tx(b);
      chk("tx resume", {24'h0, tx_q.pop_front()}, {24'h0, b});
      apb(1'b1, `ADDR_FCR, 32'h0000_0040);
      apb(1'b1, `ADDR_MCR, 32'h0000_0040);
      // rts control bit is read-only now, so this bit must not land
      apb(1'b1, `ADDR_MCR, 32'h0000_0042);
      apb(1'b0, `ADDR_MCR, 32'h0);
      chk("mcr auto", 32'h0000_0042, rd);
      go <= 1'b1;
      for (i = 0; i < 4000 && rts_n !== 1'b1; i++)
         @(posedge pclk);
      if (rts_n !== 1'b1)
         hang;
      apb(1'b0, `ADDR_STAT, 32'h0);
      chk("level at rts", 32'h4, {27'h0, rd[4:0]});
      apb(1'b0, `ADDR_MCR, 32'h0);
      chk("mcr rts high", 32'h0000_0040, rd);
      repeat (400) @(posedge pclk);
      go <= 1'b0;
      apb(1'b0, `ADDR_STAT, 32'h0);
      chk("late byte", 32'h5, {27'h0, rd[4:0]});
      cnt = 5;
      rts_m = 1'b1;
      while (rx_q.size() > 0)
      begin
         apb(1'b0, `ADDR_DATA, 32'h0);
         chk("rx byte", {24'h0, rx_q.pop_front()}, rd);
         cnt--;
         if (cnt <= 1)
            rts_m = 1'b0;
         repeat (2) @(posedge pclk);
         chk_pin("rts level", rts_m, rts_n);
      end
      apb(1'b1, `ADDR_MCR, 32'h0);
      repeat (2) @(posedge pclk);
      chk_pin("rts after auto", 1'b1, rts_n);
      apb(1'b1, `ADDR_IMR, 32'h1);
      apb(1'b0, `ADDR_MSR, 32'h0);
      // every enable mix, with cts, dsr or dcd as the changing input
      for (i = 0; i < 16; i++)
      begin
         apb(1'b1, `ADDR_MER, {28'h0, i[0], 3'h0});
         apb(1'b1, `ADDR_MCR, {24'h0, i[1], 7'h0});
         apb(1'b1, `ADDR_IER, {24'h0, i[2], 7'h0});
         apb(1'b1, `ADDR_ISR, 32'h7);
         if (i[3] && i[1])
            dsr_n <= !dsr_n;
         else if (i[3])
            dcd_n <= !dcd_n;
         else
            cts_req <= !cts_req;
         repeat (10) @(posedge pclk);
         rts_m = i[0] && (i[3] || !i[1] || i[2]);
         chk_pin("modem irq", rts_m, irq);
         apb(1'b0, `ADDR_MSR, 32'h0);
         b = {4'h0, i[3] & !i[1], 1'b0, i[3] & i[1], !i[3]};
         chk("modem deltas", {24'h0, b}, {28'h0, rd[3:0]});
      end
      // every trigger selection must be accepted and read back
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, `ADDR_FCR, {24'h0, i[1:0], 6'h00});
         apb(1'b0, `ADDR_FCR, 32'h0);
         chk("fcr read", {24'h0, i[1:0], 6'h00}, rd);
      end
      give_verdict;
   end
endmodule

// >>> test/uart_partner.sv
module uart_partner #(
   parameter int BIT = 16
) (
   // clock and flow control from the device
   input  wire logic pclk,
   input  wire logic rts_n,
   // bench controls
   input  wire logic go,
   input  wire logic cts_req,
   // lines towards the device
   output logic      rxd,
   output logic      cts_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] val;
   logic       more;
   // bench moves cts well before the last stop midpoint
   always @(posedge pclk)
      cts_n <= !cts_req;
   initial
   begin
      rxd = 1'b1;
      val = 8'h30;
      more = 1'b0;
      forever
      begin
         @(posedge pclk);
         if (more || (go && !rts_n))
         begin
            rxd <= 1'b0;
            repeat (BIT) @(posedge pclk);
            for (int j = 0; j < 8; j++)
            begin
               rxd <= val[j];
               repeat (BIT) @(posedge pclk);
            end
            // decided as the stop bit starts: one byte may outrun rts
            more = go && !rts_n;
            rxd <= 1'b1;
            val = val + 8'h01;
            repeat (BIT) @(posedge pclk);
         end
      end
   end
endmodule
